// ### design/xi_ctrl.sv
// extra external interrupt controller with eight-source arbiter and four-bit port
`timescale 1ns/1ps
`include "xi_defs.svh"

module xi_ctrl (
    input wire logic clk, // 125 MHz system clock
    input wire logic reset, // synchronous, active high
    input xi_pkg::xi_sfr_req_t sfr_req, // byte access from core
    input xi_pkg::xi_bit_req_t bit_req, // bit access from core
    output logic [7:0] sfr_rdata, // byte read data
    output logic bit_rdata, // bit read data
    output logic rd_valid, // read data valid pulse
    input wire logic [5:0] std_req, // standard sources, enabled requests
    input wire logic [5:0] std_pri, // standard sources, high priority
    input wire logic irq_ack, // core vectors to irq_out.src
    output xi_pkg::xi_irq_t irq_out, // arbitrated request and vector
    input wire logic [3:0] pin_in, // port pin levels
    output logic [3:0] pin_out, // port pin drive level
    output logic [3:0] pin_oe // port pin pull-down enable
);
    import xi_pkg::*;

    xi_state_t s_q;
    xi_state_t s_d;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] vec_of(input logic [2:0] src);
        vec_of = `XI_VEC_BASE + {2'b00, src, 3'b000};
    endfunction

    function automatic logic [3:0] lowest_set(input logic [7:0] m);
        logic [3:0] r;
        r = 4'h8;
        for (int i = 7; i >= 0; i--) begin
            if (m[i]) begin
                r = {1'b0, i[2:0]};
            end
        end
        lowest_set = r;
    endfunction

    function automatic logic is_ctrl(input logic [7:0] a);
        is_ctrl = (a & `XI_BIT_BASE_MASK) == `XI_CTRL_ADDR;
    endfunction

    function automatic logic is_port(input logic [7:0] a);
        is_port = (a & `XI_BIT_BASE_MASK) == `XI_PORT_ADDR;
    endfunction

    // ------------------------------------------------------------
    // request view of the two extra inputs
    // ------------------------------------------------------------
    logic low_a;
    logic low_b;
    logic fall_a;
    logic fall_b;
    logic [7:0] ctrl_view;
    logic [7:0] all_req;
    logic [7:0] all_hi;
    logic [3:0] pick_hi;
    logic [3:0] pick_lo;

    always_comb begin
        // only the second synchroniser stage is looked at
        low_a = !s_q.sync2[`XI_PIN_A];
        low_b = !s_q.sync2[`XI_PIN_B];
        fall_a = s_q.prev[`XI_PIN_A] && low_a;
        fall_b = s_q.prev[`XI_PIN_B] && low_b;
        // level mode shows the live request in the flag position
        ctrl_view = s_q.ctrl;
        if (!s_q.ctrl[`XI_B_IRQ2_EDGE]) begin
            ctrl_view[`XI_B_IRQ2_FLAG] = low_a;
        end
        if (!s_q.ctrl[`XI_B_IRQ3_EDGE]) begin
            ctrl_view[`XI_B_IRQ3_FLAG] = low_b;
        end
        all_req = {ctrl_view[`XI_B_IRQ3_FLAG] && s_q.ctrl[`XI_B_IRQ3_EN],
                   ctrl_view[`XI_B_IRQ2_FLAG] && s_q.ctrl[`XI_B_IRQ2_EN],
                   std_req};
        all_hi = {s_q.ctrl[`XI_B_IRQ3_PRI], s_q.ctrl[`XI_B_IRQ2_PRI], std_pri};
        pick_hi = lowest_set(all_req & all_hi);
        pick_lo = lowest_set(all_req & ~all_hi);
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.rvalid = 1'b0;
        s_d.sync1 = pin_in;
        s_d.sync2 = s_q.sync1;
        s_d.prev = s_q.sync2;

        // byte writes
        if (sfr_req.wr) begin
            case (sfr_req.addr)
                `XI_CTRL_ADDR: s_d.ctrl = sfr_req.wdata;
                `XI_PORT_ADDR: s_d.latch = sfr_req.wdata[3:0];
                default: ;
            endcase
        end

        // single-bit set and clear
        if (bit_req.wr) begin
            if (is_ctrl(bit_req.addr)) begin
                s_d.ctrl[bit_req.addr[2:0]] = bit_req.val;
            end else if (is_port(bit_req.addr) && !bit_req.addr[2]) begin
                s_d.latch[bit_req.addr[1:0]] = bit_req.val;
            end
        end

        // servicing clears the latched edge flag of the vectored source
        if (irq_ack && s_q.irq.req) begin
            if (s_q.irq.src == `XI_SRC_A) begin
                s_d.ctrl[`XI_B_IRQ2_FLAG] = 1'b0;
            end
            if (s_q.irq.src == `XI_SRC_B) begin
                s_d.ctrl[`XI_B_IRQ3_FLAG] = 1'b0;
            end
        end

        // detection last, so a new edge beats any clear in the same cycle
        if (s_q.ctrl[`XI_B_IRQ2_EDGE]) begin
            if (fall_a) begin
                s_d.ctrl[`XI_B_IRQ2_FLAG] = 1'b1;
            end
        end else begin
            s_d.ctrl[`XI_B_IRQ2_FLAG] = 1'b0;
        end
        if (s_q.ctrl[`XI_B_IRQ3_EDGE]) begin
            if (fall_b) begin
                s_d.ctrl[`XI_B_IRQ3_FLAG] = 1'b1;
            end
        end else begin
            s_d.ctrl[`XI_B_IRQ3_FLAG] = 1'b0;
        end

        // reads: port gives pins, or the latch for read-modify-write
        if (sfr_req.rd) begin
            s_d.rvalid = 1'b1;
            case (sfr_req.addr)
                `XI_CTRL_ADDR: s_d.rdata = ctrl_view;
                `XI_PORT_ADDR: s_d.rdata = {4'h0, sfr_req.rd_latch ? s_q.latch : s_q.sync2};
                default: s_d.rdata = 8'h00;
            endcase
        end
        if (bit_req.rd) begin
            s_d.rvalid = 1'b1;
            if (is_ctrl(bit_req.addr)) begin
                s_d.rbit = ctrl_view[bit_req.addr[2:0]];
            end else if (is_port(bit_req.addr) && !bit_req.addr[2]) begin
                s_d.rbit = s_q.sync2[bit_req.addr[1:0]];
            end else begin
                s_d.rbit = 1'b0;
            end
        end

        // arbitration: any high-priority request beats every low one
        s_d.irq.req = 1'b0;
        s_d.irq.high = 1'b0;
        s_d.irq.src = 3'h0;
        if (!pick_hi[3]) begin
            s_d.irq.req = 1'b1;
            s_d.irq.high = 1'b1;
            s_d.irq.src = pick_hi[2:0];
        end else if (!pick_lo[3]) begin
            s_d.irq.req = 1'b1;
            s_d.irq.src = pick_lo[2:0];
        end
        // withdraw the request for one cycle after an ack of an offered request so the acked source is not offered twice
        if (irq_ack && s_q.irq.req) begin
            s_d.irq.req = 1'b0;
        end
        s_d.irq.vector = vec_of(s_d.irq.src);
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            s_q <= '0;
            s_q.ctrl <= `XI_CTRL_RESET;
            s_q.latch <= `XI_PORT_RESET;
            s_q.sync1 <= `XI_PIN_RESET;
            s_q.sync2 <= `XI_PIN_RESET;
            s_q.prev <= `XI_PIN_RESET;
            s_q.irq.vector <= `XI_VEC_BASE;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // quasi-bidirectional: strong low only, external pull-up makes the one
    always_comb begin
        pin_out = 4'h0;
        pin_oe = ~s_q.latch;
        sfr_rdata = s_q.rdata;
        bit_rdata = s_q.rbit;
        rd_valid = s_q.rvalid;
        irq_out = s_q.irq;
    end

endmodule

// ### design/xi_defs.svh
// register addresses, bit positions, reset values and fixed codes for the extra interrupt block
`ifndef XI_DEFS_SVH
`define XI_DEFS_SVH

// ------------------------------------------------------------
// special function register addresses
// ------------------------------------------------------------
`define XI_CTRL_ADDR 8'hc0
`define XI_PORT_ADDR 8'hd8
`define XI_BIT_BASE_MASK 8'hf8

// ------------------------------------------------------------
// control register bit positions
// ------------------------------------------------------------
`define XI_B_IRQ3_PRI 7
`define XI_B_IRQ3_EN 6
`define XI_B_IRQ3_FLAG 5
`define XI_B_IRQ2_PRI 4
`define XI_B_IRQ3_EDGE 3
`define XI_B_IRQ2_EN 2
`define XI_B_IRQ2_FLAG 1
`define XI_B_IRQ2_EDGE 0

// ------------------------------------------------------------
// port pins carrying the extra requests, source numbers
// ------------------------------------------------------------
`define XI_PIN_A 2
`define XI_PIN_B 3
`define XI_SRC_A 3'h6
`define XI_SRC_B 3'h7

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define XI_CTRL_RESET 8'h00
`define XI_PORT_RESET 4'hf
`define XI_PIN_RESET 4'hf

// ------------------------------------------------------------
// vector table: first vector and spacing
// ------------------------------------------------------------
`define XI_VEC_BASE 8'h03
`define XI_VEC_STEP_SHIFT 3

`endif

// ### design/xi_pkg.sv
// types shared by the extra interrupt block and its surroundings
package xi_pkg;

    // byte access from the core's special function register bus
    typedef struct packed {
        logic wr;
        logic rd;
        logic rd_latch;
        logic [7:0] addr;
        logic [7:0] wdata;
    } xi_sfr_req_t;

    // single-bit access (set, clear, test) by bit address
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic val;
    } xi_bit_req_t;

    // request offered to the core's interrupt sequencer
    typedef struct packed {
        logic req;
        logic high;
        logic [2:0] src;
        logic [7:0] vector;
    } xi_irq_t;

    // whole state of the block
    typedef struct packed {
        logic [7:0] ctrl;
        logic [3:0] latch;
        logic [3:0] sync1;
        logic [3:0] sync2;
        logic [3:0] prev;
        logic [7:0] rdata;
        logic rbit;
        logic rvalid;
        xi_irq_t irq;
    } xi_state_t;

endpackage

// ### test/xi_ctrl_sva.sv
// port assertions for the extra interrupt block
`timescale 1ns/1ps
module xi_ctrl_chk (
    input wire logic clk, // clock
    input wire logic reset, // reset
    input xi_pkg::xi_sfr_req_t sfr_req, // byte access
    input xi_pkg::xi_bit_req_t bit_req, // bit access
    input wire logic [7:0] sfr_rdata, // byte data
    input wire logic bit_rdata, // bit data
    input wire logic rd_valid, // read valid
    input wire logic [5:0] std_req, // std requests
    input wire logic [5:0] std_pri, // std priority
    input wire logic irq_ack, // take pulse
    input xi_pkg::xi_irq_t irq_out, // offered irq
    input wire logic [3:0] pin_in, // pins
    input wire logic [3:0] pin_out, // drive level
    input wire logic [3:0] pin_oe // pull enable
);
    import xi_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    logic [5:0] req_q, pri_q;
    always_ff @(posedge clk) begin
        req_q <= std_req;
        pri_q <= std_pri;
    end
    sequence s_src0_held;
        (std_req[0] && std_pri[0] && !irq_ack) [*3];
    endsequence
    a_read_valid_next: assert property ((sfr_req.rd || bit_req.rd) |=> rd_valid) else $error("no valid");
    a_vector_from_src: assert property (irq_out.req |-> irq_out.vector == 8'h03 + {irq_out.src, 3'h0})
        else $error("bad vector");
    a_pin_drive_low: assert property (pin_out == 4'h0) else $error("pin level");
    a_src0_first: assert property (s_src0_held |-> irq_out.req && irq_out.src == 3'h0 && irq_out.high)
        else $error("src0 lost");
    a_ack_drops_req: assert property (irq_ack |=> !irq_out.req) else $error("req kept");
    a_std_src_cause: assert property (irq_out.req && irq_out.src < 3'h6 |-> req_q[irq_out.src]
        && irq_out.high == pri_q[irq_out.src]) else $error("std cause");
    a_rdata_holds: assert property (!(sfr_req.rd || bit_req.rd) |=> $stable(sfr_rdata) && $stable(bit_rdata))
        else $error("rdata moved");
    a_oe_holds: assert property (!(sfr_req.wr || bit_req.wr) |=> $stable(pin_oe)) else $error("oe moved");
    a_high_group_first: assert property (irq_out.req && !irq_out.high |-> $past(std_req & std_pri) == 6'h00)
        else $error("low beat high");
endmodule
bind xi_ctrl xi_ctrl_chk i_xi_ctrl_chk (.clk, .reset, .sfr_req, .bit_req, .sfr_rdata, .bit_rdata, .rd_valid,
    .std_req, .std_pri, .irq_ack, .irq_out, .pin_in, .pin_out, .pin_oe);

// ### test/xi_far_mdl.sv
// core sequencer and pin side model for the extra interrupt block
`timescale 1ns/1ps
module xi_far_mdl (
    input wire logic clk, // clock
    input wire logic reset, // reset
    input wire logic ack_en, // take offers
    input wire logic [3:0] pin_drv, // 0 pulls low
    input wire logic [3:0] pin_oe, // block pulls low
    input xi_pkg::xi_irq_t irq_out, // offered irq
    output logic irq_ack, // take pulse
    output logic [3:0] pin_in // wire level
);
    import xi_pkg::*;
    // pulled-up wire, low if either side pulls
    assign pin_in = pin_drv & ~pin_oe;
    always_ff @(posedge clk) begin
        if (reset) begin
            irq_ack <= 1'b0;
        end else begin
            irq_ack <= ack_en & irq_out.req & ~irq_ack;
        end
    end
endmodule

// ### test/test_xi_ctrl.sv
// directed test of the extra interrupt block
`timescale 1ns/1ps
module test_xi_ctrl;
    import xi_pkg::*;
    logic clk, reset, bit_rdata, rd_valid, irq_ack, ack_en;
    xi_sfr_req_t sfr_req;
    xi_bit_req_t bit_req;
    xi_irq_t irq_out;
    logic [7:0] sfr_rdata;
    logic [5:0] std_req, std_pri;
    logic [3:0] pin_in, pin_oe, pin_drv;
    int errors = 0;
    int n_compared = 0;
    xi_ctrl i_xi_ctrl (.clk, .reset, .sfr_req, .bit_req, .sfr_rdata, .bit_rdata, .rd_valid, .std_req, .std_pri,
        .irq_ack, .irq_out, .pin_in, .pin_out(), .pin_oe);
    xi_far_mdl i_xi_far_mdl (.clk, .reset, .ack_en, .pin_drv, .pin_oe, .irq_out, .irq_ack, .pin_in);
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
        sfr_req = '{wr: 1'b1, rd: 1'b0, rd_latch: 1'b0, addr: a, wdata: d};
        tick(1);
        sfr_req.wr = 1'b0;
        tick(1);
    endtask
    task automatic sfr_rd(input string what, input logic [7:0] a, input logic lat, input logic [7:0] exp);
        sfr_req = '{wr: 1'b0, rd: 1'b1, rd_latch: lat, addr: a, wdata: 8'h00};
        tick(1);
        sfr_req.rd = 1'b0;
        check("rd_valid", {7'h00, rd_valid}, 8'h01);
        check(what, sfr_rdata, exp);
        tick(1);
    endtask
    // bounded wait, the model may be acking meanwhile
    task automatic wait_req(input logic [2:0] s);
        int k;
        k = 0;
        while (irq_out.req !== 1'b1 && k < 20) begin
            tick(1);
            k++;
        end
        check("irq req", {7'h00, irq_out.req}, 8'h01);
        check("irq src", {5'h00, irq_out.src}, {5'h00, s});
        check("irq vector", irq_out.vector, 8'h03 + {2'b00, s, 3'b000});
    endtask
    task automatic bit_rd(input string what, input logic [7:0] a, input logic exp);
        bit_req = '{wr: 1'b0, rd: 1'b1, addr: a, val: 1'b0};
        tick(1);
        bit_req.rd = 1'b0;
        check("bit rd_valid", {7'h00, rd_valid}, 8'h01);
        check(what, {7'h00, bit_rdata}, {7'h00, exp});
        tick(1);
    endtask
    task automatic bit_wr(input logic [7:0] a, input logic v);
        bit_req = '{wr: 1'b1, rd: 1'b0, addr: a, val: v};
        tick(1);
        bit_req.wr = 1'b0;
        tick(1);
    endtask
    task automatic tally_and_finish;
        if (errors == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #100000;
        errors++;
        tally_and_finish;
    end
    initial begin
        reset = 1'b1;
        sfr_req = '0;
        bit_req = '0;
        std_req = 6'h00;
        std_pri = 6'h00;
        ack_en = 1'b0;
        pin_drv = 4'hf;
        tick(10);
        reset = 1'b0;
        sfr_rd("ctrl reset", 8'hc0, 1'b0, 8'h00);
        sfr_rd("port latch", 8'hd8, 1'b1, 8'h0f);
        sfr_rd("unmapped", 8'h80, 1'b0, 8'h00);
        bit_req = '{wr: 1'b1, rd: 1'b0, addr: 8'hc2, val: 1'b1};
        tick(1);
        bit_req.wr = 1'b0;
        sfr_rd("enable a", 8'hc0, 1'b0, 8'h04);
        bit_rd("enable bit a", 8'hc2, 1'b1);
        bit_rd("enable bit b", 8'hc6, 1'b0);
        sfr_wr(8'hc0, 8'h4d);
        pin_drv = 4'hb;
        wait_req(3'h6);
        sfr_rd("flag a set", 8'hc0, 1'b0, 8'h4f);
        ack_en = 1'b1;
        tick(3);
        ack_en = 1'b0;
        tick(2);
        sfr_rd("flag a clear", 8'hc0, 1'b0, 8'h4d);
        check("no request", {7'h00, irq_out.req}, 8'h00);
        pin_drv = 4'h3;
        wait_req(3'h7);
        sfr_rd("flag b set", 8'hc0, 1'b0, 8'h6d);
        sfr_wr(8'hc0, 8'h44);
        sfr_rd("level flags", 8'hc0, 1'b0, 8'h66);
        bit_rd("level flag b", 8'hc5, 1'b1);
        wait_req(3'h6);
        sfr_wr(8'hc0, 8'hc4);
        std_req = 6'h01;
        ack_en = 1'b1;
        tick(6);
        wait_req(3'h7);
        std_pri = 6'h01;
        tick(3);
        wait_req(3'h0);
        ack_en = 1'b0;
        sfr_wr(8'hc0, 8'h00);
        pin_drv = 4'hf;
        std_pri = 6'h3f;
        for (int i = 0; i < 6; i++) begin
            std_req = 6'h01 << i;
            tick(3);
            wait_req(i[2:0]);
        end
        std_req = 6'h00;
        sfr_wr(8'hd8, 8'h0a);
        tick(4);
        check("pin pull", {4'h0, pin_oe}, 8'h05);
        sfr_rd("pin levels", 8'hd8, 1'b0, 8'h0a);
        bit_rd("pin bit 1", 8'hd9, 1'b1);
        bit_rd("pin bit 0", 8'hd8, 1'b0);
        bit_wr(8'hd8, 1'b1);
        bit_wr(8'hd9, 1'b0);
        tick(3);
        check("pin pull bits", {4'h0, pin_oe}, 8'h06);
        sfr_rd("pin levels b", 8'hd8, 1'b0, 8'h09);
        bit_wr(8'hdc, 1'b1);
        sfr_wr(8'h80, 8'hff);
        sfr_rd("latch kept", 8'hd8, 1'b1, 8'h09);
        bit_rd("bit beyond port", 8'hdc, 1'b0);
        // latch low on pin 2 pulls the request pin, level mode shows it
        sfr_rd("ctrl kept", 8'hc0, 1'b0, 8'h02);
        tally_and_finish;
    end
endmodule
